//--- src/sbpc_pkg.sv
// Package with register map, field layout and timing constants of the share bus / power-on bank
package sbpc_pkg;

    // ============================================================
    // Register offsets
    localparam logic [7:0] SBPC_OFS_BANDWIDTH = 8'h29;
    localparam logic [7:0] SBPC_OFS_SETTING   = 8'h2a;
    localparam logic [7:0] SBPC_OFS_TEMPTRIM  = 8'h2b;
    localparam logic [7:0] SBPC_OFS_POWERON   = 8'h2c;

    // ============================================================
    // Reset values
    localparam logic [7:0] SBPC_RST_BANDWIDTH = 8'h00;
    localparam logic [7:0] SBPC_RST_SETTING   = 8'h00;
    localparam logic [7:0] SBPC_RST_TEMPTRIM  = 8'h00;
    localparam logic [7:0] SBPC_RST_POWERON   = 8'h00;

    // ============================================================
    // Field positions
    localparam int SBPC_BIT_STREAM_SEL = 4;
    localparam int SBPC_BIT_CS_SEL     = 3;
    localparam int SBPC_BW_MSB         = 2;
    localparam int SBPC_DROP_LSB       = 4;
    localparam int SBPC_TOL_MSB        = 3;
    localparam int SBPC_BIT_GAIN_NEG   = 4;
    localparam int SBPC_TRIM_MSB       = 3;
    localparam int SBPC_SRC_LSB        = 6;
    localparam int SBPC_BIT_SW_ON      = 5;

    // Gain trim scale: correction = reading * trim >> shift (15/128 ~ 12 %)
    localparam int SBPC_TRIM_SHIFT     = 7;

    // ============================================================
    // Timing
    localparam int SBPC_CLK_HZ         = 40000000;
    localparam int SBPC_BW_BASE_CYC    = 4;   // Step period at highest bandwidth
    localparam int SBPC_BIT_DIV_CYC    = 2;   // Clocks per bit-stream bit

    // Power-on source codes
    typedef enum logic [1:0] {
        SBPC_SRC_ALWAYS = 2'b00,
        SBPC_SRC_PIN    = 2'b01,
        SBPC_SRC_SOFT   = 2'b10,
        SBPC_SRC_BOTH   = 2'b11
    } sbpc_src_t;

endpackage : sbpc_pkg

//--- src/sbpc_bitstream.sv
// Pulse-density serializer turning a current reading into a one-bit stream
`timescale 1ns/1ps
module sbpc_bitstream #(
    parameter int W       = 12,
    parameter int DIV_CYC = sbpc_pkg::SBPC_BIT_DIV_CYC
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic [W-1:0] value_in,
    output logic              bit_out
);
    import sbpc_pkg::*;

    logic [15:0]  div_r;
    logic         step;
    logic [W-1:0] acc_r;
    logic [W:0]   sum;

    // ============================================================
    // Bit rate divider
    assign step = (div_r == 16'(DIV_CYC - 1));

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_r <= 16'h0000;
        end else if (step) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_r + 16'h0001;
        end
    end

    // First-order accumulator; carry is the stream bit
    assign sum = {1'b0, acc_r} + {1'b0, value_in};

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            acc_r   <= '0;
            bit_out <= 1'b0;
        end else if (step) begin
            acc_r   <= sum[W-1:0];
            bit_out <= sum[W];
        end
    end

endmodule // sbpc_bitstream

//--- src/sbpc_bank.sv
// Share bus and power-on configuration register bank with its steering logic
// Functional notes
// - Stream select 1: share pin carries selected current reading as bit stream.
// - Stream select 0: share pin carries the digital share-bus signal.
// - Source select 1 uses primary sense reading, 0 uses secondary.
// - Three-bit bandwidth code; 000 slowest share loop, 111 fastest.
// - Upper nibble sets voltage drop applied when acting as master.
// - Lower nibble sets slave-to-master current match window; larger is wider.
// - Gain polarity 1 subtracts correction, 0 adds it.
// - Four-bit trim scales temperature reading by up to about twelve percent.
// - Source code 00 keeps supply enabled regardless of pin and bit.
// - Source code 01 follows the hardware power-on pin only.
// - Source code 10 follows the software power-on bit only.
// - Source code 11 enables only when both bit and pin are set.
`timescale 1ns/1ps
module sbpc_bank #(
    parameter int CS_W   = 12,
    parameter int TEMP_W = 12
) (
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire logic [7:0]        reg_addr_in,
    input  wire logic [7:0]        reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic      [7:0]        reg_rdata_out,
    output logic                   reg_rvalid_out,
    input  wire logic [CS_W-1:0]   primary_current_sense_in,
    input  wire logic [CS_W-1:0]   secondary_current_sense_in,
    input  wire logic              digital_share_in,
    input  wire logic [CS_W-1:0]   master_current_in,
    input  wire logic              is_master_in,
    input  wire logic [TEMP_W-1:0] temperature_sensor_in,
    input  wire logic              hardware_power_on_pin_in,
    output logic                   share_out_pin_out,
    output logic      [CS_W-1:0]   share_reading_out,
    output logic                   share_step_out,
    output logic      [3:0]        master_drop_out,
    output logic                   share_ok_out,
    output logic      [TEMP_W-1:0] temperature_trimmed_out,
    output logic                   power_enable_out
);
    import sbpc_pkg::*;

    // ============================================================
    // Functions

    // Step period for a bandwidth code, halving per code step
    function automatic logic [15:0] bw_period(input logic [2:0] code);
        bw_period = 16'(SBPC_BW_BASE_CYC) << (3'd7 - code);
    endfunction

    // Absolute difference of two readings
    function automatic logic [CS_W-1:0] abs_diff(input logic [CS_W-1:0] a, input logic [CS_W-1:0] b);
        abs_diff = (a >= b) ? (a - b) : (b - a);
    endfunction

    // ============================================================
    // Registers
    logic [7:0] bandwidth_r;
    logic [7:0] setting_r;
    logic [7:0] temptrim_r;
    logic [7:0] poweron_r;
    logic [7:0] rdata_nxt;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bandwidth_r <= SBPC_RST_BANDWIDTH;
            setting_r   <= SBPC_RST_SETTING;
            temptrim_r  <= SBPC_RST_TEMPTRIM;
            poweron_r   <= SBPC_RST_POWERON;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                SBPC_OFS_BANDWIDTH: bandwidth_r <= reg_wdata_in;
                SBPC_OFS_SETTING:   setting_r   <= reg_wdata_in;
                SBPC_OFS_TEMPTRIM:  temptrim_r  <= reg_wdata_in; // Reserved [7:5] kept as written
                SBPC_OFS_POWERON:   poweron_r   <= reg_wdata_in;
                default:            ;
            endcase
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        case (reg_addr_in)
            SBPC_OFS_BANDWIDTH: rdata_nxt = bandwidth_r;
            SBPC_OFS_SETTING:   rdata_nxt = setting_r;
            SBPC_OFS_TEMPTRIM:  rdata_nxt = temptrim_r;
            SBPC_OFS_POWERON:   rdata_nxt = poweron_r;
            default:            rdata_nxt = 8'h00;
        endcase
    end

    // Read data registered one cycle after strobe
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out  <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                reg_rdata_out <= rdata_nxt;
            end
        end
    end

    // ============================================================
    // Current share path
    logic            stream_bit;
    logic [CS_W-1:0] sel_reading;

    assign sel_reading = bandwidth_r[SBPC_BIT_CS_SEL] ? primary_current_sense_in : secondary_current_sense_in;

    sbpc_bitstream #(
        .W       (CS_W),
        .DIV_CYC (SBPC_BIT_DIV_CYC)
    ) u_stream (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .value_in (share_reading_out),
        .bit_out  (stream_bit)
    );

    // Share pin source mux, covers stream and digital cases
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            share_reading_out <= '0;
            share_out_pin_out <= 1'b0;
        end else begin
            share_reading_out <= sel_reading;
            // Digital share signal when stream off
            share_out_pin_out <= bandwidth_r[SBPC_BIT_STREAM_SEL] ? stream_bit : digital_share_in;
        end
    end

    // ============================================================
    // Share loop update rate
    logic [15:0] bw_cnt_r;

    // Faster step for higher bandwidth code
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bw_cnt_r       <= 16'h0000;
            share_step_out <= 1'b0;
        end else if (bw_cnt_r >= bw_period(bandwidth_r[SBPC_BW_MSB:0]) - 16'h0001) begin
            bw_cnt_r       <= 16'h0000;
            share_step_out <= 1'b1;
        end else begin
            bw_cnt_r       <= bw_cnt_r + 16'h0001;
            share_step_out <= 1'b0;
        end
    end

    // Master drop and slave match window
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            master_drop_out <= 4'h0;
            share_ok_out    <= 1'b0;
        end else begin
            master_drop_out <= is_master_in ? setting_r[7:SBPC_DROP_LSB] : 4'h0;
            share_ok_out    <= is_master_in ||
                (abs_diff(share_reading_out, master_current_in) <= CS_W'(setting_r[SBPC_TOL_MSB:0]));
        end
    end

    // ============================================================
    // Temperature gain trim
    logic [TEMP_W+3:0] trim_prod;
    logic [TEMP_W-1:0] trim_corr;
    logic [TEMP_W:0]   trim_sum;

    // Correction is reading * trim / 128
    assign trim_prod = temperature_sensor_in * temptrim_r[SBPC_TRIM_MSB:0];
    assign trim_corr = TEMP_W'(trim_prod >> SBPC_TRIM_SHIFT);
    assign trim_sum  = {1'b0, temperature_sensor_in} + {1'b0, trim_corr};

    // Polarity chooses subtract or saturating add
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            temperature_trimmed_out <= '0;
        end else if (temptrim_r[SBPC_BIT_GAIN_NEG]) begin
            temperature_trimmed_out <= temperature_sensor_in - trim_corr;
        end else if (trim_sum[TEMP_W]) begin
            temperature_trimmed_out <= '1;
        end else begin
            temperature_trimmed_out <= trim_sum[TEMP_W-1:0];
        end
    end

    // ============================================================
    // Power-on source selection
    logic      pin_meta_r;
    logic      pin_sync_r;
    logic      sw_on;
    sbpc_src_t src;

    // Two-stage synchroniser for the hardware pin
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
        end else begin
            pin_meta_r <= hardware_power_on_pin_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    assign sw_on = poweron_r[SBPC_BIT_SW_ON];
    assign src   = sbpc_src_t'(poweron_r[7:SBPC_SRC_LSB]);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            power_enable_out <= 1'b0;
        end else begin
            case (src)
                SBPC_SRC_ALWAYS: power_enable_out <= 1'b1;
                SBPC_SRC_PIN:    power_enable_out <= pin_sync_r;
                SBPC_SRC_SOFT:   power_enable_out <= sw_on;
                SBPC_SRC_BOTH:   power_enable_out <= sw_on && pin_sync_r;
                default:         power_enable_out <= 1'b0;
            endcase
        end
    end

    // ============================================================
    // Assertions

    chk_stream_pin_source:
    assert property (@(posedge clk_in) disable iff (rst_in)
        bandwidth_r[SBPC_BIT_STREAM_SEL] |=> (share_out_pin_out == $past(stream_bit)))
        else $error("share pin does not follow bit stream");

    chk_digital_pin_source:
    assert property (@(posedge clk_in) disable iff (rst_in)
        !bandwidth_r[SBPC_BIT_STREAM_SEL] |=> (share_out_pin_out == $past(digital_share_in)))
        else $error("share pin does not follow digital share signal");

    chk_sense_select:
    assert property (@(posedge clk_in) disable iff (rst_in)
        ##1 share_reading_out == ($past(bandwidth_r[SBPC_BIT_CS_SEL]) ?
            $past(primary_current_sense_in) : $past(secondary_current_sense_in)))
        else $error("wrong current sense reading selected");

    chk_bw_step_gap:
    assert property (@(posedge clk_in) disable iff (rst_in)
        share_step_out |=> (!share_step_out)[*3])
        else $error("share loop steps closer than four clocks");

    chk_bw_fast_period:
    assert property (@(posedge clk_in) disable iff (rst_in)
        (share_step_out && bandwidth_r[2:0] == 3'b111) ##1 (bandwidth_r[2:0] == 3'b111)[*3]
            |=> share_step_out)
        else $error("highest bandwidth step period wrong");

    chk_master_drop:
    assert property (@(posedge clk_in) disable iff (rst_in)
        is_master_in |=> master_drop_out == $past(setting_r[7:4]))
        else $error("master drop not applied");

    chk_slave_window:
    assert property (@(posedge clk_in) disable iff (rst_in)
        (!is_master_in && abs_diff(share_reading_out, master_current_in) > CS_W'(setting_r[3:0]))
            |=> !share_ok_out)
        else $error("slave flagged sharing outside window");

    chk_gain_negative:
    assert property (@(posedge clk_in) disable iff (rst_in)
        temptrim_r[SBPC_BIT_GAIN_NEG] |=> temperature_trimmed_out <= $past(temperature_sensor_in))
        else $error("negative gain raised the reading");

    chk_trim_zero:
    assert property (@(posedge clk_in) disable iff (rst_in)
        (temptrim_r[3:0] == 4'h0) |=> temperature_trimmed_out == $past(temperature_sensor_in))
        else $error("zero trim changed the reading");

    chk_always_on:
    assert property (@(posedge clk_in) disable iff (rst_in)
        (src == SBPC_SRC_ALWAYS) |=> power_enable_out)
        else $error("always-on source left supply off");

    chk_pin_source:
    assert property (@(posedge clk_in) disable iff (rst_in)
        (src == SBPC_SRC_PIN) |=> power_enable_out == $past(pin_sync_r))
        else $error("pin source not followed");

    chk_soft_source:
    assert property (@(posedge clk_in) disable iff (rst_in)
        (src == SBPC_SRC_SOFT) |=> power_enable_out == $past(sw_on))
        else $error("software source not followed");

    chk_both_source:
    assert property (@(posedge clk_in) disable iff (rst_in)
        (src == SBPC_SRC_BOTH && !sw_on) |=> !power_enable_out)
        else $error("both-source enabled without software bit");

    chk_write_readback:
    assert property (@(posedge clk_in) disable iff (rst_in)
        (reg_wr_in && reg_addr_in == SBPC_OFS_SETTING) |=> setting_r == $past(reg_wdata_in))
        else $error("written value not held");

endmodule // sbpc_bank

//--- tb/sbpc_host_model.sv
// Host model driving the register strobes of the share bus and power-on bank
`timescale 1ns/1ps
module sbpc_host_model (
    input  wire logic       clk_in,
    output logic      [7:0] reg_addr_out,
    output logic      [7:0] reg_wdata_out,
    output logic            reg_wr_out,
    output logic            reg_rd_out,
    input  wire logic [7:0] reg_rdata_in,
    input  wire logic       reg_rvalid_in
);
    logic [7:0] last_rd;
    logic       last_ok;

    // ============================================================
    // Idle state of the strobes
    initial begin
        reg_addr_out  = 8'h00;
        reg_wdata_out = 8'h00;
        reg_wr_out    = 1'b0;
        reg_rd_out    = 1'b0;
    end

    // One write strobe; released lines show the inverse of the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        reg_addr_out  = a;
        reg_wdata_out = d;
        reg_wr_out    = 1'b1;
        @(negedge clk_in);
        reg_wr_out    = 1'b0;
        reg_addr_out  = ~a;
        reg_wdata_out = ~d;
    endtask

    // One read strobe; answer taken one cycle later
    task automatic rd(input logic [7:0] a);
        @(negedge clk_in);
        reg_addr_out = a;
        reg_rd_out   = 1'b1;
        @(negedge clk_in);
        reg_rd_out   = 1'b0;
        reg_addr_out = ~a;
        last_ok      = reg_rvalid_in;
        last_rd      = reg_rdata_in;
    endtask

    task automatic trim_wr(input logic [4:0] d);
        wr(8'h2b, {3'b000, d});
    endtask
endmodule // sbpc_host_model

//--- tb/tb_top.sv
// Self-checking bench of the share bus and power-on register bank
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin bad_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); end end
module tb_top;
    import sbpc_pkg::*;
    logic        clk_in, rst_in, wr, rd, dshare, is_master, pin, rvalid, sh_pin, step, ok, pwr, e;
    logic [7:0]  addr, wdata, rdata, a, d;
    logic [11:0] prim, sec, mcur, temp, reading, trimmed;
    logic [3:0]  drop;
    logic [31:0] seed = 32'd60;
    logic [31:0] r;
    int          bad_count, compares, n, ones;
    int          dl[4] = '{3, 4, -3, -4};

    sbpc_bank u_dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .primary_current_sense_in(prim), .secondary_current_sense_in(sec), .digital_share_in(dshare),
        .master_current_in(mcur), .is_master_in(is_master), .temperature_sensor_in(temp),
        .hardware_power_on_pin_in(pin), .share_out_pin_out(sh_pin), .share_reading_out(reading),
        .share_step_out(step), .master_drop_out(drop), .share_ok_out(ok),
        .temperature_trimmed_out(trimmed), .power_enable_out(pwr));

    sbpc_host_model u_host (.clk_in(clk_in), .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_wr_out(wr),
        .reg_rd_out(rd), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid));

    // ============================================================
    // Expectation helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic exp_pwr(logic [1:0] c, logic s, logic p);
        case (c)
            2'b00: return 1'b1;
            2'b01: return p;
            2'b10: return s;
            default: return s & p;
        endcase
    endfunction

    function automatic logic [11:0] exp_trim(logic [11:0] raw, logic neg, logic [3:0] t);
        logic [16:0] corr;
        logic [12:0] sum;
        corr = ({5'h00, raw} * {13'h0000, t}) >> 7;
        sum  = {1'b0, raw} + {1'b0, corr[11:0]};
        if (neg) return raw - corr[11:0];
        return sum[12] ? 12'hfff : sum[11:0];
    endfunction

    task automatic cyc(input int k);
        repeat (k) @(negedge clk_in);
    endtask

    // Bounded wait for the next share-loop tick, cycles counted
    task automatic wait_step(output int k);
        k = 0;
        do begin
            @(negedge clk_in);
            k++;
        end while (step !== 1'b1 && k < 600);
        if (k >= 600) begin
            bad_count++;
            wrap_up();
        end
    endtask

    task automatic count_ones(output int k);
        k = 0;
        repeat (64) begin
            @(negedge clk_in);
            k += int'(sh_pin === 1'b1);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ============================================================
    // Clock
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    // Main sequence
    initial begin
        rst_in = 1'b1; dshare = 1'b0; is_master = 1'b0; pin = 1'b0;
        prim = 12'h000; sec = 12'h000; mcur = 12'h000; temp = 12'h000;
        repeat (6) @(posedge clk_in);
        @(negedge clk_in);
        rst_in = 1'b0;
        for (int i = 0; i < 5; i++) begin
            u_host.rd(8'h29 + 8'(i));
            `CHK("reset_read", 8'h00, u_host.last_rd)
            `CHK("read_valid", 1'b1, u_host.last_ok)
        end
        for (int i = 0; i < 24; i++) begin
            a = 8'h29 + 8'(i % 4);
            d = 8'(rnd());
            u_host.wr(a, d);
            u_host.rd(a);
            `CHK("reg_rw", d, u_host.last_rd)
        end
        u_host.wr(8'h30, 8'hff);
        u_host.rd(8'h30);
        `CHK("unmapped", 8'h00, u_host.last_rd)
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            u_host.wr(SBPC_OFS_POWERON, {i[3:2], i[1], 5'h00});
            pin = i[0];
            cyc(5);
            `CHK("power_enable", exp_pwr(i[3:2], i[1], i[0]), pwr)
        end
        $display("test power done");
        for (int i = 0; i < 8; i++) begin
            prim = 12'(rnd());
            sec  = 12'(rnd());
            u_host.wr(SBPC_OFS_BANDWIDTH, {4'h0, i[0], 3'h7});
            cyc(3);
            `CHK("share_reading", i[0] ? prim : sec, reading)
        end
        for (int i = 0; i < 20; i++) begin
            r = rnd();
            dshare = r[9];
            e = dshare;
            @(negedge clk_in);
            `CHK("share_pin_digital", e, sh_pin)
        end
        dshare = 1'b1;
        prim = 12'h000;
        u_host.wr(SBPC_OFS_BANDWIDTH, 8'h1f);
        cyc(4);
        count_ones(ones);
        `CHK("stream_zero", 0, ones)
        prim = 12'h800;
        cyc(4);
        count_ones(ones);
        `CHK("stream_half", 1'b1, ones >= 24 && ones <= 40)
        $display("test share pin done");
        for (int c = 7; c >= 0; c--) begin
            u_host.wr(SBPC_OFS_BANDWIDTH, {5'h00, 3'(c)});
            wait_step(n);
            wait_step(n);
            `CHK("step_period", 4 << (7 - c), n)
        end
        $display("test bandwidth done");
        u_host.wr(SBPC_OFS_SETTING, 8'h53);
        sec = 12'd1000;
        for (int i = 0; i < 4; i++) begin
            mcur = 12'(1000 + dl[i]);
            cyc(3);
            `CHK("share_ok", dl[i] inside {[-3:3]}, ok)
            `CHK("drop_slave", 4'h0, drop)
        end
        is_master = 1'b1;
        cyc(3);
        `CHK("drop_master", 4'h5, drop)
        `CHK("ok_master", 1'b1, ok)
        is_master = 1'b0;
        $display("test share setting done");
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            if (i == 0) r = 32'h000f_0fff;
            temp = r[11:0];
            u_host.trim_wr(r[20:16]);
            cyc(3);
            `CHK("temp_trim", exp_trim(r[11:0], r[20], r[19:16]), trimmed)
        end
        $display("test trim done");
        wrap_up();
    end
endmodule // tb_top
